// >>> core/pcms_pkg.sv
// shared constants for the pixel color matrix and statistics block
package pcms_pkg;
  // data path widths
  localparam int COMP_W = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int FRAC = 12;
  localparam int TBL_DEPTH = 256;
  // fixed point 1.0, rounding half, last table index
  localparam logic [15:0] ONE = 16'h1000;
  localparam logic [20:0] ROUND_HALF = 21'h000800;
  localparam logic [7:0] TBL_LAST = 8'hff;
  // register word addresses
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] HISTW_ADDR = 12'h001;
  localparam logic [11:0] STATUS_ADDR = 12'h002;
  localparam logic [11:0] DROPS_ADDR = 12'h003;
  localparam logic [11:0] MAT_BASE = 12'h010;
  localparam logic [11:0] SCALE_BASE = 12'h020;
  localparam logic [11:0] BIAS_BASE = 12'h024;
  localparam logic [11:0] MIN_BASE = 12'h028;
  localparam logic [11:0] MAX_BASE = 12'h02c;
  // table windows, chosen by address bits 11:10
  localparam logic [1:0] SEL_LUT1 = 2'h1;
  localparam logic [1:0] SEL_LUT2 = 2'h2;
  localparam logic [1:0] SEL_HIST = 2'h3;
  // control and status field positions
  localparam int CTRL_LUT1_EN = 0;
  localparam int CTRL_LUT2_EN = 1;
  localparam int CTRL_HIST_EN = 2;
  localparam int CTRL_HIST_SINK = 3;
  localparam int CTRL_MM_EN = 4;
  localparam int CTRL_MM_SINK = 5;
  localparam int CTRL_HMASK_LSB = 8;
  localparam int CTRL_MMASK_LSB = 12;
  localparam int STATUS_BUSY = 0;
  // reset values and the count table width limit
  localparam logic [3:0] HMASK_RST = 4'hf;
  localparam logic [3:0] MMASK_RST = 4'hf;
  localparam logic [8:0] HISTW_RST = 9'h000;
  localparam logic [8:0] HISTW_MAX = 9'h100;
  localparam logic [15:0] SCALE_RST = ONE;
  localparam logic [15:0] BIAS_RST = 16'h0000;
  localparam logic [15:0] MIN_RST = 16'h7fff;
  localparam logic [15:0] MAX_RST = 16'h8000;
endpackage

// >>> core/pcms_ram.sv
// one channel table: registered stream read, direct software read
`timescale 1ns/1ps

module pcms_ram (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [15:0] wdata,
  // stream read, data one cycle later
  input wire logic [7:0] raddrA,
  output logic [15:0] rdataA,
  // software read, same cycle
  input wire logic [7:0] raddrB,
  output logic [15:0] rdataB
);
  // contents carry no reset, software loads them
  logic [15:0] mem [0:pcms_pkg::TBL_DEPTH-1];

  // write and registered read; read sees the old word on a collision
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdataA <= mem[raddrA];
  end

  // software side is registered by the caller
  assign rdataB = mem[raddrB];
endmodule

// >>> core/pcms_hist_lane.sv
// one channel of count table with read-modify-write and forwarding
`timescale 1ns/1ps

module pcms_hist_lane (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // increment request
  input wire logic incValid,
  input wire logic [7:0] incIdx,
  // software access
  input wire logic swWe,
  input wire logic [7:0] swAddr,
  input wire logic [15:0] swWdata,
  output logic [15:0] swRdata
);
  // lane state
  typedef struct packed {
    logic bValid;       // increment in write stage
    logic [7:0] bIdx;   // its entry
    logic fwd;          // ram word is stale, use fwdVal
    logic [15:0] fwdVal;
  } pcms_lane_t;

  pcms_lane_t st;
  pcms_lane_t next_st;
  logic [15:0] ramQ;
  logic [15:0] incData;
  logic ramWe;
  logic [7:0] ramWaddr;
  logic [15:0] ramWdata;

  // wraps silently past the top, no error kept
  assign incData = (st.fwd ? st.fwdVal : ramQ) + 16'h0001; // see RL9
  // software write takes the port; a colliding increment is lost
  assign ramWe = swWe | st.bValid;
  assign ramWaddr = swWe ? swAddr : st.bIdx;
  assign ramWdata = swWe ? swWdata : incData;

  // next state; forward a write the ram read just missed
  always_comb begin
    next_st = st;
    next_st.bValid = incValid;
    next_st.bIdx = incIdx;
    next_st.fwd = ramWe && (ramWaddr == incIdx);
    next_st.fwdVal = ramWdata;
    if (!rst_b) begin
      next_st = '0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  pcms_ram uRam (
    .clk(clk),
    .we(ramWe),
    .waddr(ramWaddr),
    .wdata(ramWdata),
    .raddrA(incIdx),
    .rdataA(ramQ),
    .raddrB(swAddr),
    .rdataB(swRdata)
  );
endmodule

// >>> core/pcms_core.sv
// pixel group back end: lookups, color matrix, counting, extremes
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

// Contract
// RL1: stages act on rgba groups only
// RL2: post-convolution lookup enable, reset disabled
// RL3: post-convolution lookup works as generic table
// RL4: multiply rgba by four-by-four color matrix
// RL5: per-channel signed scale then signed bias
// RL6: post-matrix lookup enable, reset disabled, generic
// RL7: index is clamped component times width-1, rounded
// RL8: increment selected entry per present channel
// RL9: count overflow undefined, no error
// RL10: count sink drops groups, else passes
// RL11: dropped by counting means no extremes tracking
// RL12: counting and extremes have separate enables
// RL13: replace minimum if smaller, maximum if larger
// RL14: extremes kept at least color range
// RL15: extremes sink drops groups, else passes
// RL16: drops produce no output, still signal completion
// RL17: order lookup, matrix, lookup, count, extremes
module pcms_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [pcms_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pcms_pkg::DATA_W-1:0] regWdata,
  input wire logic regWe,
  input wire logic regRe,
  output logic [pcms_pkg::DATA_W-1:0] regRdata,
  // incoming group from convolution
  input wire logic inValid,
  input wire logic inRgba,
  input wire logic [15:0] inRed,
  input wire logic [15:0] inGreen,
  input wire logic [15:0] inBlue,
  input wire logic [15:0] inAlpha,
  // outgoing group to texture store
  output logic outValid,
  output logic outRgba,
  output logic [15:0] outRed,
  output logic [15:0] outGreen,
  output logic [15:0] outBlue,
  output logic [15:0] outAlpha,
  output logic outDone
);
  // all state in one record
  typedef struct packed {
    logic lut1En;              // post-convolution lookup
    logic lut2En;              // post-matrix lookup
    logic histEn;
    logic histSink;
    logic mmEn;
    logic mmSink;
    logic [3:0] histMask;      // channels held by count table
    logic [3:0] mmMask;        // channels held by extremes table
    logic [8:0] histW;         // count table width, 0 = off
    logic [15:0][15:0] mat;    // row major color matrix
    logic [3:0][15:0] scale;
    logic [3:0][15:0] bias;
    logic [3:0][15:0] mn;
    logic [3:0][15:0] mx;
    logic [15:0] drops;        // groups swallowed by a sink
    logic [31:0] rdata;
    logic v1, r1;
    logic [3:0][15:0] c1;      // input, lookup data beside it
    logic v2, r2;
    logic [3:0][15:0] c2;      // after matrix
    logic v3, r3;
    logic [3:0][15:0] c3;      // after scale and bias
    logic v4, r4;
    logic [3:0][15:0] c4;      // post-matrix lookup beside it
    logic oValid, oRgba, oDone;
    logic [3:0][15:0] oC;
  } pcms_state_t;

  pcms_state_t st;
  pcms_state_t next_st;

  // stream components and table data
  logic [3:0][15:0] inC;
  logic [3:0][15:0] a1;        // stage 1 after lookup
  logic [3:0][15:0] a4;        // stage 4 after lookup
  logic [3:0][15:0] lut1Q, lut2Q;
  logic [3:0][15:0] lut1Rd, lut2Rd, histRd;
  logic [3:0] lut1We, lut2We, histWe, histInc;
  logic [3:0][7:0] lut1Idx, lut2Idx, histIdx;
  logic [1:0] sel;
  logic [1:0] selCh;
  logic [7:0] histWm1;
  logic histDrop, mmDo, mmDrop;

  // fixed point [0,1] to table index, nearest integer
  function automatic logic [7:0] toIndex(input logic [15:0] c, input logic [7:0] wm1);
    logic [12:0] cl;
    logic [20:0] prod;
    if (c[15]) begin
      cl = 13'h0000;
    end else if (c > pcms_pkg::ONE) begin
      cl = pcms_pkg::ONE[12:0];
    end else begin
      cl = c[12:0];
    end
    // widen both factors first; a product sized by its operands keeps only 13 bits
    prod = 21'(cl) * 21'(wm1) + pcms_pkg::ROUND_HALF; // see RL7
    return prod[19:12];
  endfunction

  // saturate a wide signed value into a component
  function automatic logic [15:0] sat(input logic signed [35:0] v);
    if (v > 36'sh00007fff) begin
      return 16'h7fff;
    end else if (v < -36'sh000008000) begin
      return 16'h8000;
    end else begin
      return v[15:0];
    end
  endfunction

  assign inC = {inAlpha, inBlue, inGreen, inRed};
  assign sel = regAddr[11:10];
  assign selCh = regAddr[9:8];
  assign histWm1 = 8'(st.histW - 9'h001);

  // sink decisions: counting drops first, extremes never see it
  assign histDrop = st.v4 && st.r4 && st.histEn && st.histSink; // see RL10
  assign mmDo = st.v4 && st.r4 && st.mmEn && !histDrop; // see RL11 see RL12
  assign mmDrop = mmDo && st.mmSink; // see RL15

  // per channel tables, index and lookup select
  for (genvar ch = 0; ch < 4; ch++) begin : gCh
    assign lut1Idx[ch] = toIndex(inC[ch], pcms_pkg::TBL_LAST);
    assign lut2Idx[ch] = toIndex(st.c3[ch], pcms_pkg::TBL_LAST);
    assign histIdx[ch] = toIndex(a4[ch], histWm1);
    assign lut1We[ch] = regWe && sel == pcms_pkg::SEL_LUT1 && selCh == 2'(ch);
    assign lut2We[ch] = regWe && sel == pcms_pkg::SEL_LUT2 && selCh == 2'(ch);
    assign histWe[ch] = regWe && sel == pcms_pkg::SEL_HIST && selCh == 2'(ch);
    // generic table replaces the component, rgba only
    assign a1[ch] = (st.lut1En && st.r1) ? lut1Q[ch] : st.c1[ch]; // see RL1 see RL3
    assign a4[ch] = (st.lut2En && st.r4) ? lut2Q[ch] : st.c4[ch]; // see RL6
    // count only rgba groups and channels the table holds
    assign histInc[ch] = st.v4 && st.r4 && st.histEn && st.histW != 9'h000
                         && st.histMask[ch]; // see RL8

    pcms_ram uLut1 (
      .clk(clk),
      .we(lut1We[ch]),
      .waddr(regAddr[7:0]),
      .wdata(regWdata[15:0]),
      .raddrA(lut1Idx[ch]),
      .rdataA(lut1Q[ch]),
      .raddrB(regAddr[7:0]),
      .rdataB(lut1Rd[ch])
    );

    pcms_ram uLut2 (
      .clk(clk),
      .we(lut2We[ch]),
      .waddr(regAddr[7:0]),
      .wdata(regWdata[15:0]),
      .raddrA(lut2Idx[ch]),
      .rdataA(lut2Q[ch]),
      .raddrB(regAddr[7:0]),
      .rdataB(lut2Rd[ch])
    );

    pcms_hist_lane uHist (
      .clk(clk),
      .rst_b(rst_b),
      .incValid(histInc[ch]),
      .incIdx(histIdx[ch]),
      .swWe(histWe[ch]),
      .swAddr(regAddr[7:0]),
      .swWdata(regWdata[15:0]),
      .swRdata(histRd[ch])
    );
  end

  // pipeline, register file and statistics
  always_comb begin
    logic signed [35:0] acc;
    logic [31:0] rd;
    acc = '0;
    rd = '0;
    next_st = st;

    // stage 1: group in, post-convolution lookup read issued
    next_st.v1 = inValid; // see RL17
    next_st.r1 = inValid && inRgba;
    next_st.c1 = inC;

    // stage 2: color matrix on the looked-up group
    next_st.v2 = st.v1;
    next_st.r2 = st.r1;
    for (int i = 0; i < 4; i++) begin
      acc = '0;
      for (int k = 0; k < 4; k++) begin
        acc = acc + $signed(st.mat[i * 4 + k]) * $signed(a1[k]); // see RL4
      end
      next_st.c2[i] = st.r1 ? sat(acc >>> pcms_pkg::FRAC) : a1[i];
    end

    // stage 3: scale then bias, result replaces the group
    next_st.v3 = st.v2;
    next_st.r3 = st.r2;
    for (int i = 0; i < 4; i++) begin
      acc = $signed(st.c2[i]) * $signed(st.scale[i]);
      acc = (acc >>> pcms_pkg::FRAC) + 36'($signed(st.bias[i])); // see RL5
      next_st.c3[i] = st.r2 ? sat(acc) : st.c2[i];
    end

    // stage 4: post-matrix lookup read issued from stage 3
    next_st.v4 = st.v3;
    next_st.r4 = st.r3;
    next_st.c4 = st.c3;

    // output: dropped groups leave no data, completion still shown
    next_st.oValid = st.v4 && !histDrop && !mmDrop; // see RL16
    next_st.oRgba = st.r4;
    next_st.oC = a4;
    next_st.oDone = st.v4;
    if (histDrop || mmDrop) begin
      next_st.drops = st.drops + 16'h0001;
    end

    // software writes to own registers
    if (regWe && sel == 2'h0) begin
      if (regAddr == pcms_pkg::CTRL_ADDR) begin
        next_st.lut1En = regWdata[pcms_pkg::CTRL_LUT1_EN];
        next_st.lut2En = regWdata[pcms_pkg::CTRL_LUT2_EN];
        next_st.histEn = regWdata[pcms_pkg::CTRL_HIST_EN]; // see RL12
        next_st.histSink = regWdata[pcms_pkg::CTRL_HIST_SINK];
        next_st.mmEn = regWdata[pcms_pkg::CTRL_MM_EN];
        next_st.mmSink = regWdata[pcms_pkg::CTRL_MM_SINK];
        next_st.histMask = regWdata[pcms_pkg::CTRL_HMASK_LSB +: 4];
        next_st.mmMask = regWdata[pcms_pkg::CTRL_MMASK_LSB +: 4];
      end else if (regAddr == pcms_pkg::HISTW_ADDR) begin
        // widths beyond the table are held at its size
        if (regWdata[15:0] > 16'(pcms_pkg::HISTW_MAX)) begin
          next_st.histW = pcms_pkg::HISTW_MAX;
        end else begin
          next_st.histW = regWdata[8:0];
        end
      end else if (regAddr == pcms_pkg::DROPS_ADDR) begin
        next_st.drops = regWdata[15:0];
      end else if (regAddr[11:4] == pcms_pkg::MAT_BASE[11:4]) begin
        next_st.mat[regAddr[3:0]] = regWdata[15:0];
      end else if (regAddr[11:2] == pcms_pkg::SCALE_BASE[11:2]) begin
        next_st.scale[regAddr[1:0]] = regWdata[15:0];
      end else if (regAddr[11:2] == pcms_pkg::BIAS_BASE[11:2]) begin
        next_st.bias[regAddr[1:0]] = regWdata[15:0];
      end else if (regAddr[11:2] == pcms_pkg::MIN_BASE[11:2]) begin
        next_st.mn[regAddr[1:0]] = regWdata[15:0];
      end else if (regAddr[11:2] == pcms_pkg::MAX_BASE[11:2]) begin
        next_st.mx[regAddr[1:0]] = regWdata[15:0];
      end
    end

    // extremes tracking; the stream update wins over a software write
    for (int i = 0; i < 4; i++) begin
      if (mmDo && st.mmMask[i]) begin
        if ($signed(a4[i]) < $signed(st.mn[i])) begin
          next_st.mn[i] = a4[i]; // see RL13 see RL14
        end
        if ($signed(a4[i]) > $signed(st.mx[i])) begin
          next_st.mx[i] = a4[i]; // see RL13
        end
      end
    end

    // read mux, data stand only in the cycle after the strobe
    if (sel == pcms_pkg::SEL_LUT1) begin
      rd = {16'h0000, lut1Rd[selCh]};
    end else if (sel == pcms_pkg::SEL_LUT2) begin
      rd = {16'h0000, lut2Rd[selCh]};
    end else if (sel == pcms_pkg::SEL_HIST) begin
      rd = {16'h0000, histRd[selCh]};
    end else if (regAddr == pcms_pkg::CTRL_ADDR) begin
      rd[pcms_pkg::CTRL_LUT1_EN] = st.lut1En;
      rd[pcms_pkg::CTRL_LUT2_EN] = st.lut2En;
      rd[pcms_pkg::CTRL_HIST_EN] = st.histEn;
      rd[pcms_pkg::CTRL_HIST_SINK] = st.histSink;
      rd[pcms_pkg::CTRL_MM_EN] = st.mmEn;
      rd[pcms_pkg::CTRL_MM_SINK] = st.mmSink;
      rd[pcms_pkg::CTRL_HMASK_LSB +: 4] = st.histMask;
      rd[pcms_pkg::CTRL_MMASK_LSB +: 4] = st.mmMask;
    end else if (regAddr == pcms_pkg::HISTW_ADDR) begin
      rd = {23'h000000, st.histW};
    end else if (regAddr == pcms_pkg::STATUS_ADDR) begin
      rd[pcms_pkg::STATUS_BUSY] = st.v1 | st.v2 | st.v3 | st.v4;
    end else if (regAddr == pcms_pkg::DROPS_ADDR) begin
      rd = {16'h0000, st.drops};
    end else if (regAddr[11:4] == pcms_pkg::MAT_BASE[11:4]) begin
      rd = {16'h0000, st.mat[regAddr[3:0]]};
    end else if (regAddr[11:2] == pcms_pkg::SCALE_BASE[11:2]) begin
      rd = {16'h0000, st.scale[regAddr[1:0]]};
    end else if (regAddr[11:2] == pcms_pkg::BIAS_BASE[11:2]) begin
      rd = {16'h0000, st.bias[regAddr[1:0]]};
    end else if (regAddr[11:2] == pcms_pkg::MIN_BASE[11:2]) begin
      rd = {16'h0000, st.mn[regAddr[1:0]]};
    end else if (regAddr[11:2] == pcms_pkg::MAX_BASE[11:2]) begin
      rd = {16'h0000, st.mx[regAddr[1:0]]};
    end
    next_st.rdata = regRe ? rd : 32'h00000000;

    // synchronous reset: lookups and statistics off, identity transform
    if (!rst_b) begin
      next_st = '0;
      next_st.lut1En = 1'b0; // see RL2
      next_st.lut2En = 1'b0; // see RL6
      next_st.histMask = pcms_pkg::HMASK_RST;
      next_st.mmMask = pcms_pkg::MMASK_RST;
      next_st.histW = pcms_pkg::HISTW_RST;
      for (int i = 0; i < 4; i++) begin
        next_st.mat[i * 5] = pcms_pkg::ONE;
        next_st.scale[i] = pcms_pkg::SCALE_RST;
        next_st.bias[i] = pcms_pkg::BIAS_RST;
        next_st.mn[i] = pcms_pkg::MIN_RST;
        next_st.mx[i] = pcms_pkg::MAX_RST;
      end
    end
  end

  // one register for the whole record
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // outputs straight from the record
  assign regRdata = st.rdata;
  assign outValid = st.oValid;
  assign outRgba = st.oRgba;
  assign outRed = st.oC[0];
  assign outGreen = st.oC[1];
  assign outBlue = st.oC[2];
  assign outAlpha = st.oC[3];
  assign outDone = st.oDone;
endmodule

// >>> test/pcms_core_monitor.sv
// port-level assertion checker for the pixel group back end
`timescale 1ns/1ps
module pcms_core_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWe,
  input wire logic regRe,
  input wire logic [31:0] regRdata,
  // stream
  input wire logic inValid,
  input wire logic inRgba,
  input wire logic [15:0] inRed,
  input wire logic [15:0] inAlpha,
  input wire logic outValid,
  input wire logic outRgba,
  input wire logic [15:0] outRed,
  input wire logic [15:0] outAlpha,
  input wire logic outDone
);
  logic [15:0] ctrlCopy; // shadow of the control word
  logic ctrlWr; // control write this cycle
  logic dropOn; // either sink would drop an rgba group
  assign ctrlWr = regWe && regAddr == pcms_pkg::CTRL_ADDR;
  assign dropOn = (ctrlCopy[2] && ctrlCopy[3]) || (ctrlCopy[4] && ctrlCopy[5]);
  // shadow follows software writes; masks reset to all channels
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrlCopy <= 16'hff00;
    end else if (ctrlWr) begin
      ctrlCopy <= regWdata[15:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_done_lat; inValid |-> ##5 outDone; endproperty
  a_done_lat: assert property (p_done_lat) else $error("group not completed after five cycles");
  property p_done_cause; outDone |-> $past(inValid, 5); endproperty
  a_done_cause: assert property (p_done_cause) else $error("completion without a group");
  property p_valid_done; outValid |-> outDone; endproperty
  a_valid_done: assert property (p_valid_done) else $error("delivery without completion");
  property p_bypass;
    inValid && !inRgba |-> ##5 outValid && !outRgba && outRed == $past(inRed, 5) && outAlpha == $past(inAlpha, 5);
  endproperty
  a_bypass: assert property (p_bypass) else $error("non-rgba group altered");
  // ctrl must stay quiet over the whole flight so the expectation is unambiguous
  property p_drop; (inValid && inRgba && !ctrlWr) ##1 (!ctrlWr) [*4] |-> ##1 (outValid == !dropOn); endproperty
  a_drop: assert property (p_drop) else $error("sink decision wrong");
  property p_rd_idle; !$past(regRe) |-> regRdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
  property p_ctrl_rd;
    $past(regRe) && $past(regAddr) == pcms_pkg::CTRL_ADDR |-> (regRdata[15:0] & 16'hff3f) == ($past(ctrlCopy) & 16'hff3f);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
  property p_rgba_flag; outValid |-> outRgba == $past(inRgba, 5); endproperty
  a_rgba_flag: assert property (p_rgba_flag) else $error("group kind flag lost");
endmodule
bind pcms_core pcms_core_monitor mon_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
  .regWe(regWe), .regRe(regRe), .regRdata(regRdata), .inValid(inValid), .inRgba(inRgba), .inRed(inRed),
  .inAlpha(inAlpha), .outValid(outValid), .outRgba(outRgba), .outRed(outRed), .outAlpha(outAlpha),
  .outDone(outDone));

// >>> test/pcms_store_model.sv
// downstream texture store stand-in: tallies delivered and completed groups
`timescale 1ns/1ps
module pcms_store_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // group from the block
  input wire logic outValid,
  input wire logic outDone,
  // tallies for the bench
  output int nStored,
  output int nDone
);
  // store never back-pressures, so it just counts each pulse
  always @(posedge clk) begin
    if (!rst_b) begin
      nStored <= 0;
      nDone <= 0;
    end else begin
      if (outValid) begin
        nStored <= nStored + 1;
      end
      if (outDone) begin
        nDone <= nDone + 1;
      end
    end
  end
endmodule

// >>> test/pcms_core_tb.sv
// self-checking bench for the pixel group back end
`timescale 1ns/1ps
module pcms_core_tb;
  logic clk;
  logic rst_b;
  logic [11:0] regAddr;
  logic [31:0] regWdata;
  logic regWe;
  logic regRe;
  logic [31:0] regRdata;
  logic inValid;
  logic inRgba;
  logic [15:0] inRed, inGreen, inBlue, inAlpha;
  logic outValid, outRgba, outDone;
  logic [15:0] outRed, outGreen, outBlue, outAlpha;
  int nStored, nDone, nMismatch, cmpCount, nSent, nKept;
  logic [15:0] pix [4]; // next group to send
  logic [15:0] expPix [4]; // expected output components
  logic [7:0] lutIdx [4] = '{8'h40, 8'h20, 8'h10, 8'hff}; // table index of each base component
  logic [7:0] cntIdx [4] = '{8'h02, 8'h00, 8'h03, 8'h01}; // count index at width four
  logic [15:0] minExp [4] = '{16'h0400, 16'hff00, 16'h0100, 16'h0555};
  logic [15:0] maxExp [4] = '{16'h0800, 16'h0200, 16'h2000, 16'h1000};
  pcms_core dut_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe),
    .regRe(regRe), .regRdata(regRdata), .inValid(inValid), .inRgba(inRgba), .inRed(inRed), .inGreen(inGreen),
    .inBlue(inBlue), .inAlpha(inAlpha), .outValid(outValid), .outRgba(outRgba), .outRed(outRed),
    .outGreen(outGreen), .outBlue(outBlue), .outAlpha(outAlpha), .outDone(outDone));
  pcms_store_model store_u (.clk(clk), .rst_b(rst_b), .outValid(outValid), .outDone(outDone),
    .nStored(nStored), .nDone(nDone));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    regWe <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWe <= 1'b0;
  endtask
  // read, data sampled in the single cycle it stands
  task automatic rchk(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk);
    regRe <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRe <= 1'b0;
    #1;
    chk(regRdata, {16'h0, e});
  endtask
  // one group in; outputs stand one cycle, four edges after the taking edge
  task automatic grp(input logic rgba, input logic keep);
    @(posedge clk);
    inValid <= 1'b1;
    inRgba <= rgba;
    {inRed, inGreen, inBlue, inAlpha} <= {pix[0], pix[1], pix[2], pix[3]};
    @(posedge clk);
    inValid <= 1'b0;
    nSent++;
    repeat (4) @(posedge clk);
    #1;
    chk(outDone, 1'b1);
    chk(outValid, keep);
    if (keep) begin
      nKept++;
      chk({outRed, outGreen}, {expPix[0], expPix[1]});
      chk({outBlue, outAlpha}, {expPix[2], expPix[3]});
      chk(outRgba, rgba);
    end
  endtask
  task automatic endSim;
    $display("mismatches %0d of %0d compares", nMismatch, cmpCount);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  initial begin
    #1000000;
    nMismatch++;
    endSim;
  end
  initial begin
    {rst_b, regAddr, regWdata, regWe, regRe, inValid, inRgba} = '0;
    {inRed, inGreen, inBlue, inAlpha} = '0;
    {nMismatch, cmpCount, nSent, nKept} = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    // reset values; unmapped word reads zero and ignores writes
    rchk(pcms_pkg::CTRL_ADDR, 16'hff00);
    rchk(pcms_pkg::HISTW_ADDR, 16'h0000);
    rchk(pcms_pkg::STATUS_ADDR, 16'h0000);
    // oversize width is held at the table size
    wr(pcms_pkg::HISTW_ADDR, 32'h0fff);
    rchk(pcms_pkg::HISTW_ADDR, 16'h0100);
    wr(12'h004, 32'h1234);
    rchk(12'h004, 16'h0000);
    rchk(12'h011, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      rchk(12'h010 + 12'(c * 5), 16'h1000);
      rchk(12'h020 + 12'(c), 16'h1000);
      rchk(12'h024 + 12'(c), 16'h0000);
      rchk(12'h028 + 12'(c), 16'h7fff);
      rchk(12'h02c + 12'(c), 16'h8000);
    end
    // matrix mixes half green into red, then red scale 2 and bias; scale before bias
    pix = '{16'h0400, 16'h0200, 16'h0100, 16'h1000};
    wr(12'h011, 32'h0800);
    wr(12'h020, 32'h2000);
    wr(12'h024, 32'h0010);
    expPix = '{16'h0a10, 16'h0200, 16'h0100, 16'h1000};
    grp(1'b1, 1'b1);
    wr(12'h011, 32'h0);
    wr(12'h020, 32'h1000);
    wr(12'h024, 32'h0);
    // first table maps every channel to one half, second maps one half to a channel tag
    for (int c = 0; c < 4; c++) begin
      wr({2'h1, 2'(c), lutIdx[c]}, 32'h0800);
      wr({2'h2, 2'(c), 8'h80}, 32'h0100 + 32'(c));
    end
    wr(pcms_pkg::CTRL_ADDR, 32'hff01);
    expPix = '{16'h0800, 16'h0800, 16'h0800, 16'h0800};
    grp(1'b1, 1'b1);
    wr(pcms_pkg::CTRL_ADDR, 32'hff03);
    expPix = '{16'h0100, 16'h0101, 16'h0102, 16'h0103};
    grp(1'b1, 1'b1);
    expPix = pix;
    grp(1'b0, 1'b1);
    // counting at width four, tables cleared first, stream untouched
    wr(pcms_pkg::HISTW_ADDR, 32'h4);
    for (int c = 0; c < 16; c++) begin
      wr({2'h3, 2'(c / 4), 8'(c % 4)}, 32'h0);
    end
    wr(pcms_pkg::CTRL_ADDR, 32'hff04);
    pix = '{16'h0800, 16'hff00, 16'h2000, 16'h0555};
    expPix = pix;
    grp(1'b1, 1'b1);
    grp(1'b1, 1'b1);
    for (int c = 0; c < 4; c++) begin
      rchk({2'h3, 2'(c), cntIdx[c]}, 16'h0002);
    end
    rchk({4'hc, 8'h03}, 16'h0000);
    // red channel only in the mask
    wr(pcms_pkg::CTRL_ADDR, 32'hf104);
    grp(1'b1, 1'b1);
    rchk({4'hc, 8'h02}, 16'h0003);
    rchk({4'hd, 8'h00}, 16'h0002);
    // full entry wraps silently, group still delivered
    wr({4'hc, 8'h02}, 32'hffff);
    grp(1'b1, 1'b1);
    rchk({4'hc, 8'h02}, 16'h0000);
    rchk(pcms_pkg::MIN_BASE, 16'h7fff);
    // extremes only, signed values
    wr(pcms_pkg::CTRL_ADDR, 32'hff10);
    grp(1'b1, 1'b1);
    pix = '{16'h0400, 16'h0200, 16'h0100, 16'h1000};
    expPix = pix;
    grp(1'b1, 1'b1);
    for (int c = 0; c < 4; c++) begin
      rchk(pcms_pkg::MIN_BASE + 12'(c), minExp[c]);
      rchk(pcms_pkg::MAX_BASE + 12'(c), maxExp[c]);
    end
    rchk({4'hc, 8'h02}, 16'h0000);
    // count sink drops before extremes; extremes sink drops after
    pix = '{16'h0100, 16'h0300, 16'h0300, 16'h0800};
    wr(pcms_pkg::CTRL_ADDR, 32'hff1c);
    grp(1'b1, 1'b0);
    rchk(pcms_pkg::MIN_BASE, 16'h0400);
    wr(pcms_pkg::CTRL_ADDR, 32'hff30);
    grp(1'b1, 1'b0);
    rchk(pcms_pkg::MIN_BASE, 16'h0100);
    rchk(pcms_pkg::DROPS_ADDR, 16'h0002);
    expPix = pix;
    grp(1'b0, 1'b1);
    // the store model tallies the last pulse one edge after it appears
    repeat (2) @(posedge clk);
    #1;
    chk(32'(nDone), 32'(nSent));
    chk(32'(nStored), 32'(nKept));
    endSim;
  end
endmodule
